// ### include/pcer_defines.vh
// Offsets, field positions and reset values of the correctable error register block
`ifndef PCER_DEFINES_VH
`define PCER_DEFINES_VH

// ==========================================================================
// Register offsets (extended configuration space byte addresses)
`define PCER_OFS_COR_STATUS 12'h110
`define PCER_OFS_COR_MASK 12'h114
`define PCER_OFS_CAP_CTRL 12'h118
`define PCER_OFS_HDR_LOG0 12'h11C
`define PCER_OFS_HDR_LOG1 12'h120
`define PCER_OFS_HDR_LOG2 12'h124
`define PCER_OFS_HDR_LOG3 12'h128

// ==========================================================================
// Correctable status / mask bit positions
`define PCER_BIT_ADVISORY 13
`define PCER_BIT_RETX_TIMER 12
`define PCER_BIT_REPLAY_ROLL 8
`define PCER_BIT_LINK_PKT 7
`define PCER_BIT_TRANS_PKT 6
`define PCER_BIT_RX_CODING 0
`define PCER_COR_IMPL_BITS 32'h000031C1

// ==========================================================================
// Capability and control field positions
`define PCER_BIT_CHECK_EN 8
`define PCER_BIT_CHECK_SUP 7
`define PCER_BIT_GEN_EN 6
`define PCER_BIT_GEN_SUP 5
`define PCER_FEP_MSB 4
`define PCER_FEP_LSB 0

// ==========================================================================
// Reset values
`define PCER_RST_COR_STATUS 32'h00000000
`define PCER_RST_COR_MASK 32'h00002000
`define PCER_RST_CAP_CTRL 32'h000000A0
`define PCER_RST_FEP 5'h00
`define PCER_RST_HDR 32'h00000000

`endif

// ### verilog/pcer_regs.v
// Correctable error status, mask, ECRC capability/control and header log registers
`include "pcer_defines.vh"

// Behaviour
// (R1) Status bits are sticky; only a written one or reset clears them.
// (R2) Advisory non-fatal error report sets status bit 13.
// (R3) Retransmit timer expiry with unacknowledged packet sets status bit 12.
// (R4) Replay attempt counter rollover sets status bit 8.
// (R5) Coding error during DLLP reception sets status bit 7.
// (R6) Coding error during TLP reception sets status bit 6.
// (R7) Any coding error sets status bit 0.
// (R8) Unused status and mask bits are read-only and read zero.
// (R9) Masked error sets no status, sends no message, loads no log or pointer.
// (R10) Mask bits 13,12,8,7,6,0 writable; reset value 0000_2000h.
// (R11) Control bit 8 enables ECRC checking of received packets.
// (R12) Control bit 6 enables ECRC generation on transmitted packets.
// (R13) Capability bits 7 and 5 always read one.
// (R14) Field 4:0 holds position of first detected uncorrectable error class.
// (R15) All fields return to defaults on link, global or power-on reset.
// (R16) Capability/control reads 0000_00A0h after reset.
// (R17) Header of most recent error packet captured in four-word log at 11Ch.
// (R18) Unmasked correctable error requests a correctable error message upstream.
module pcer_regs (
    input wire CLK,
    input wire RST,
    input wire LINK_RESET_N,
    input wire GLOBAL_RESET_PIN_N,
    input wire CFG_WR,
    input wire CFG_RD,
    input wire [11:0] CFG_ADDR,
    input wire [31:0] CFG_WDATA,
    input wire [3:0] CFG_BYTE_EN,
    input wire ADVISORY_NONFATAL_EVENT,
    input wire RETRANSMIT_TIMER_EVENT,
    input wire REPLAY_ROLLOVER_EVENT,
    input wire PHY_CODING_ERROR,
    input wire RX_DLLP_ACTIVE,
    input wire RX_TLP_ACTIVE,
    input wire UNCOR_ERROR_EVENT,
    input wire [4:0] UNCOR_ERROR_POS,
    input wire UNCOR_STATUS_CLEARED,
    input wire HDR_LOG_LOAD,
    input wire [127:0] HDR_LOG_DATA,
    output reg [31:0] CFG_RDATA,
    output reg CFG_RD_VALID,
    output reg CORR_MSG_REQ,
    output reg END_CRC_CHECK_ENABLE,
    output reg END_CRC_GENERATE_ENABLE
);

    // ======================================================================
    // Reset sources
    // Both pins come from outside the core clock, so each passes two flops
    // before it joins the power-on reset.
    // Pin levels are captured raw, so no logic sits ahead of the first flop.
    reg link_rst_n_meta_ff;
    reg link_rst_n_sync_ff;
    reg glob_rst_n_meta_ff;
    reg glob_rst_n_sync_ff;
    wire any_rst;

    always @(posedge CLK) begin
        if (RST) begin
            link_rst_n_meta_ff <= 1'b0;
            link_rst_n_sync_ff <= 1'b0;
            glob_rst_n_meta_ff <= 1'b0;
            glob_rst_n_sync_ff <= 1'b0;
        end else begin
            link_rst_n_meta_ff <= LINK_RESET_N;
            link_rst_n_sync_ff <= link_rst_n_meta_ff;
            glob_rst_n_meta_ff <= GLOBAL_RESET_PIN_N;
            glob_rst_n_sync_ff <= glob_rst_n_meta_ff;
        end
    end

    assign any_rst = RST | ~link_rst_n_sync_ff | ~glob_rst_n_sync_ff; // R15

    // ======================================================================
    // Byte-lane write data and address decode
    reg [31:0] wr_bits;
    integer i;

    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            wr_bits[i*8 +: 8] = CFG_BYTE_EN[i] ? CFG_WDATA[i*8 +: 8] : 8'h00;
        end
    end

    wire wr_status = CFG_WR & (CFG_ADDR == `PCER_OFS_COR_STATUS);
    wire wr_mask = CFG_WR & (CFG_ADDR == `PCER_OFS_COR_MASK);
    wire wr_ctrl = CFG_WR & (CFG_ADDR == `PCER_OFS_CAP_CTRL);

    // ======================================================================
    // Error events
    reg [31:0] raw_events;
    reg [31:0] mask_ff;
    wire [31:0] live_events;

    always @* begin
        raw_events = 32'h00000000;
        raw_events[`PCER_BIT_ADVISORY] = ADVISORY_NONFATAL_EVENT; // R2
        raw_events[`PCER_BIT_RETX_TIMER] = RETRANSMIT_TIMER_EVENT; // R3
        raw_events[`PCER_BIT_REPLAY_ROLL] = REPLAY_ROLLOVER_EVENT; // R4
        raw_events[`PCER_BIT_LINK_PKT] = PHY_CODING_ERROR & RX_DLLP_ACTIVE; // R5
        raw_events[`PCER_BIT_TRANS_PKT] = PHY_CODING_ERROR & RX_TLP_ACTIVE; // R6
        raw_events[`PCER_BIT_RX_CODING] = PHY_CODING_ERROR; // R7
    end

    // A masked event is dropped here, before it can touch status or message
    assign live_events = raw_events & ~mask_ff & `PCER_COR_IMPL_BITS; // R9

    // ======================================================================
    // Correctable error status: set wins over a clear in the same cycle
    reg [31:0] status_ff;
    wire [31:0] nxt_status;

    assign nxt_status = ((status_ff & ~(wr_status ? wr_bits : 32'h00000000))
                         | live_events) & `PCER_COR_IMPL_BITS; // R1 R8

    always @(posedge CLK) begin
        if (any_rst) begin
            status_ff <= `PCER_RST_COR_STATUS; // R15
        end else begin
            status_ff <= nxt_status;
        end
    end

    // ======================================================================
    // Correctable error mask
    always @(posedge CLK) begin
        if (any_rst) begin
            mask_ff <= `PCER_RST_COR_MASK; // R10 R15
        end else if (wr_mask) begin
            mask_ff <= ((mask_ff & ~{{8{CFG_BYTE_EN[3]}}, {8{CFG_BYTE_EN[2]}},
                         {8{CFG_BYTE_EN[1]}}, {8{CFG_BYTE_EN[0]}}}) | wr_bits)
                       & `PCER_COR_IMPL_BITS; // R10 R8
        end
    end

    // ======================================================================
    // Message request toward the link layer
    always @(posedge CLK) begin
        if (any_rst) begin
            CORR_MSG_REQ <= 1'b0;
        end else begin
            CORR_MSG_REQ <= |live_events; // R18 R9
        end
    end

    // ======================================================================
    // ECRC enables
    always @(posedge CLK) begin
        if (any_rst) begin
            END_CRC_CHECK_ENABLE <= 1'b0; // R15 R16
            END_CRC_GENERATE_ENABLE <= 1'b0;
        end else if (wr_ctrl) begin
            if (CFG_BYTE_EN[1]) begin
                END_CRC_CHECK_ENABLE <= CFG_WDATA[`PCER_BIT_CHECK_EN]; // R11
            end
            if (CFG_BYTE_EN[0]) begin
                END_CRC_GENERATE_ENABLE <= CFG_WDATA[`PCER_BIT_GEN_EN]; // R12
            end
        end
    end

    // ======================================================================
    // First error pointer
    // The pointer stays frozen on the first error until the uncorrectable
    // logic reports that its status bit was cleared; later errors are lost.
    reg [4:0] first_err_ff;
    reg first_held_ff;

    always @(posedge CLK) begin
        if (any_rst) begin
            first_err_ff <= `PCER_RST_FEP; // R15
            first_held_ff <= 1'b0;
        end else if (UNCOR_ERROR_EVENT & (~first_held_ff | UNCOR_STATUS_CLEARED)) begin
            first_err_ff <= UNCOR_ERROR_POS; // R14
            first_held_ff <= 1'b1;
        end else if (UNCOR_STATUS_CLEARED) begin
            first_held_ff <= 1'b0;
        end
    end

    // ======================================================================
    // Header log
    // Advisory errors carry a header, so an unmasked advisory event also
    // loads it; the other correctable errors have no packet to log.
    reg [31:0] hdr_log_ff [0:3];
    wire hdr_load = HDR_LOG_LOAD | live_events[`PCER_BIT_ADVISORY]; // R17 R9
    integer k;

    always @(posedge CLK) begin
        if (any_rst) begin
            for (k = 0; k < 4; k = k + 1) begin
                hdr_log_ff[k] <= `PCER_RST_HDR; // R15
            end
        end else if (hdr_load) begin
            for (k = 0; k < 4; k = k + 1) begin
                hdr_log_ff[k] <= HDR_LOG_DATA[k*32 +: 32]; // R17
            end
        end
    end

    // ======================================================================
    // Read path: one cycle latency, unmapped offsets read zero
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        case (CFG_ADDR)
            `PCER_OFS_COR_STATUS: rd_mux = status_ff; // R8
            `PCER_OFS_COR_MASK: rd_mux = mask_ff;
            `PCER_OFS_CAP_CTRL: begin
                rd_mux[`PCER_BIT_CHECK_EN] = END_CRC_CHECK_ENABLE;
                rd_mux[`PCER_BIT_CHECK_SUP] = 1'b1; // R13 R16
                rd_mux[`PCER_BIT_GEN_EN] = END_CRC_GENERATE_ENABLE;
                rd_mux[`PCER_BIT_GEN_SUP] = 1'b1; // R13
                rd_mux[`PCER_FEP_MSB:`PCER_FEP_LSB] = first_err_ff; // R14
            end
            `PCER_OFS_HDR_LOG0: rd_mux = hdr_log_ff[0]; // R17
            `PCER_OFS_HDR_LOG1: rd_mux = hdr_log_ff[1];
            `PCER_OFS_HDR_LOG2: rd_mux = hdr_log_ff[2];
            `PCER_OFS_HDR_LOG3: rd_mux = hdr_log_ff[3];
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge CLK) begin
        if (any_rst) begin
            CFG_RDATA <= 32'h00000000;
            CFG_RD_VALID <= 1'b0;
        end else begin
            CFG_RDATA <= CFG_RD ? rd_mux : 32'h00000000;
            CFG_RD_VALID <= CFG_RD;
        end
    end

endmodule

// ### verif/pcer_link_model.sv
// Link layer and PHY stand-in that raises error indications
module pcer_link_model (
    input logic [5:0] req,
    output logic adv,
    output logic retx,
    output logic roll,
    output logic cod,
    output logic dllp,
    output logic tlp
);
    timeunit 1ns / 1ps;
    // ========================================
    // Indications
    // Held only while requested, so each one lasts as long as its request bit is set
    assign {tlp, dllp, cod, roll, retx, adv} = req;
endmodule

// ### verif/pcer_regs_properties.sv
// Port-level properties of the correctable error register block
`include "pcer_defines.vh"
module pcer_regs_properties (
    input wire CLK,
    input wire RST,
    input wire LINK_RESET_N,
    input wire GLOBAL_RESET_PIN_N,
    input wire CFG_WR,
    input wire CFG_RD,
    input wire [11:0] CFG_ADDR,
    input wire [31:0] CFG_WDATA,
    input wire [3:0] CFG_BYTE_EN,
    input wire ADVISORY_NONFATAL_EVENT,
    input wire RETRANSMIT_TIMER_EVENT,
    input wire REPLAY_ROLLOVER_EVENT,
    input wire PHY_CODING_ERROR,
    input wire RX_DLLP_ACTIVE,
    input wire RX_TLP_ACTIVE,
    input wire [31:0] CFG_RDATA,
    input wire CFG_RD_VALID,
    input wire CORR_MSG_REQ,
    input wire END_CRC_CHECK_ENABLE,
    input wire END_CRC_GENERATE_ENABLE
);
    timeunit 1ns / 1ps;
    // ========================================
    // Properties
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    wire oth = ADVISORY_NONFATAL_EVENT | RETRANSMIT_TIMER_EVENT | REPLAY_ROLLOVER_EVENT;
    wire cwr = CFG_WR && CFG_ADDR == `PCER_OFS_CAP_CTRL;
    wire crd = CFG_RD && CFG_ADDR == `PCER_OFS_CAP_CTRL;
    wire srd = CFG_RD && CFG_ADDR == `PCER_OFS_COR_STATUS;
    property p_rsvd; CFG_RD && CFG_ADDR[11:3] == 9'h22 |=> (CFG_RDATA & 32'hFFFFCE3E) == 0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_cap; crd |=> CFG_RD_VALID && CFG_RDATA[7] && CFG_RDATA[5] && !CFG_RDATA[31:9];
    endproperty
    a_cap: assert property (p_cap) else $error("capability bits");
    property p_chk; cwr && CFG_BYTE_EN[1] |=> END_CRC_CHECK_ENABLE == $past(CFG_WDATA[8]);
    endproperty
    a_chk: assert property (p_chk) else $error("check enable");
    property p_gen; cwr && CFG_BYTE_EN[0] |=> END_CRC_GENERATE_ENABLE == $past(CFG_WDATA[6]);
    endproperty
    a_gen: assert property (p_gen) else $error("generate enable");
    property p_hold; disable iff (RST || !LINK_RESET_N || !GLOBAL_RESET_PIN_N)
        !cwr |=> $stable({END_CRC_CHECK_ENABLE, END_CRC_GENERATE_ENABLE}); endproperty
    a_hold: assert property (p_hold) else $error("enable moved");
    property p_nomsg; !(oth || PHY_CODING_ERROR) |=> !CORR_MSG_REQ; endproperty
    a_nomsg: assert property (p_nomsg) else $error("spurious message");
    property p_rx; PHY_CODING_ERROR && !oth && !RX_DLLP_ACTIVE && !RX_TLP_ACTIVE
        ##1 CORR_MSG_REQ && srd |=> CFG_RDATA[0]; endproperty
    a_rx: assert property (p_rx) else $error("coding error lost");
    property p_cwrd; cwr && CFG_BYTE_EN[1] ##1 crd |=> CFG_RDATA[8] == $past(CFG_WDATA[8], 2);
    endproperty
    a_cwrd: assert property (p_cwrd) else $error("control readback");
endmodule
bind pcer_regs pcer_regs_properties i_pcer_regs_properties (.*);

// ### verif/pcer_correctable_error_reporting_tb_top.sv
// Self-checking bench of the correctable error register block
`include "pcer_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module pcer_correctable_error_reporting_tb_top;
    timeunit 1ns / 1ps;
    logic clk = 0, rst = 1, lk = 1, gl = 1, w = 0, r = 0, ue = 0, hl = 0, uc = 0;
    logic [3:0] be = 4'hF;
    logic [11:0] a = 0;
    logic [31:0] wd = 0, mk, ex, rd_q;
    logic [4:0] pos = 0;
    logic [5:0] req = 0, e;
    logic [127:0] hd = 0;
    logic [5:0] tbl [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h18, 6'h28};
    wire [31:0] rdq;
    wire rv, msg, ce, ge, adv, rtx, rol, cod, dl, tl;
    int miscompares = 0, n_tests = 0, cyc = 0;
    // ========================================
    // Harness
    initial forever #2 clk = ~clk;
    pcer_link_model i_pcer_link_model (.req(req), .adv(adv), .retx(rtx), .roll(rol),
        .cod(cod), .dllp(dl), .tlp(tl));
    pcer_regs i_pcer_regs (.CLK(clk), .RST(rst), .LINK_RESET_N(lk), .GLOBAL_RESET_PIN_N(gl),
        .CFG_WR(w), .CFG_RD(r), .CFG_ADDR(a), .CFG_WDATA(wd), .CFG_BYTE_EN(be),
        .ADVISORY_NONFATAL_EVENT(adv), .RETRANSMIT_TIMER_EVENT(rtx),
        .REPLAY_ROLLOVER_EVENT(rol), .PHY_CODING_ERROR(cod), .RX_DLLP_ACTIVE(dl),
        .RX_TLP_ACTIVE(tl), .UNCOR_ERROR_EVENT(ue), .UNCOR_ERROR_POS(pos),
        .UNCOR_STATUS_CLEARED(uc), .HDR_LOG_LOAD(hl), .HDR_LOG_DATA(hd),
        .CFG_RDATA(rdq), .CFG_RD_VALID(rv), .CORR_MSG_REQ(msg),
        .END_CRC_CHECK_ENABLE(ce), .END_CRC_GENERATE_ENABLE(ge));
    function automatic logic [31:0] st(input logic [5:0] v);
        st = {18'h0, v[0], v[1], 3'h0, v[2], v[3] & v[4], v[3] & v[5], 5'h0, v[3]};
    endfunction
    // Tasks start and end at a falling edge so requests are stable at the rising edge
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        w = 1'h1;
        a = ad;
        wd = d;
        @(negedge clk);
        w = 1'h0;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] x);
        r = 1'h1;
        a = ad;
        @(negedge clk);
        // Read data stands for one cycle only, so look before it drops
        `CHK(rv, 1'h1)
        `CHK(rdq, x)
        r = 1'h0;
        @(negedge clk);
    endtask
    task automatic conclude;
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        mk = $urandom(59);
        repeat (8) @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
        rd(`PCER_OFS_COR_STATUS, 32'h0);
        rd(`PCER_OFS_COR_MASK, 32'h2000);
        rd(`PCER_OFS_CAP_CTRL, 32'hA0);
        rd(12'h200, 32'h0);
        wr(`PCER_OFS_COR_MASK, 32'hFFFFFFFF);
        rd(`PCER_OFS_COR_MASK, 32'h31C1);
        for (int i = 0; i < 30; i++) begin
            e = (i < 6) ? tbl[i] : 6'($urandom);
            mk = (i < 6) ? 32'h0 : $urandom & 32'h31C1;
            ex = st(e) & ~mk;
            wr(`PCER_OFS_COR_MASK, mk);
            req = e;
            @(negedge clk);
            req = 6'h0;
            `CHK(msg, |ex)
            rd(`PCER_OFS_COR_STATUS, ex);
            wr(`PCER_OFS_COR_STATUS, 32'h0);
            rd(`PCER_OFS_COR_STATUS, ex);
            wr(`PCER_OFS_COR_STATUS, 32'hFFFFFFFF);
            rd(`PCER_OFS_COR_STATUS, 32'h0);
        end
        wr(`PCER_OFS_CAP_CTRL, 32'hFFFFFFFF);
        rd(`PCER_OFS_CAP_CTRL, 32'h1E0);
        `CHK({ce, ge}, 2'h3)
        wr(`PCER_OFS_CAP_CTRL, 32'h100);
        rd(`PCER_OFS_CAP_CTRL, 32'h1A0);
        `CHK({ce, ge}, 2'h2)
        // Second pointer update lands while the first is held and must be refused
        ue = 1'h1;
        pos = 5'h5;
        @(negedge clk);
        pos = 5'h9;
        @(negedge clk);
        ue = 1'h0;
        rd(`PCER_OFS_CAP_CTRL, 32'h1A5);
        // A cleared status releases the pointer for the next error
        {ue, uc, pos} = {2'h3, 5'h9};
        @(negedge clk);
        {ue, uc} = 2'h0;
        rd(`PCER_OFS_CAP_CTRL, 32'h1A9);
        // Only lane 0 enabled: generate enable moves, check enable must not
        be = 4'h1;
        wr(`PCER_OFS_CAP_CTRL, 32'hFFFFFE40);
        be = 4'hF;
        `CHK({ce, ge}, 2'h3)
        hd = {$urandom, $urandom, $urandom, $urandom};
        hl = 1'h1;
        @(negedge clk);
        hl = 1'h0;
        for (int k = 0; k < 4; k++)
            rd(12'h11C + 12'(4 * k), hd[k * 32 +: 32]);
        // A masked advisory event must leave status, message and log alone
        ex = hd[31:0];
        hd = ~hd;
        wr(`PCER_OFS_COR_MASK, 32'h2000);
        req = 6'h01;
        @(negedge clk);
        req = 6'h0;
        `CHK(msg, 1'h0)
        rd(`PCER_OFS_HDR_LOG0, ex);
        rd(`PCER_OFS_COR_STATUS, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wr(`PCER_OFS_COR_MASK, 32'h0);
            @(negedge clk);
            wr(`PCER_OFS_CAP_CTRL, 32'h140);
            {lk, gl} = k ? 2'h2 : 2'h1;
            repeat (4) @(negedge clk);
            {lk, gl} = 2'h3;
            repeat (5) @(negedge clk);
            rd(`PCER_OFS_COR_MASK, 32'h2000);
            rd(`PCER_OFS_CAP_CTRL, 32'hA0);
            rd(`PCER_OFS_HDR_LOG0, 32'h0);
        end
        conclude();
    end
endmodule
